// File: sre_exec.sv
// stack push/pop, return and software reset executor
`timescale 1ns/1ps
`include "sre_cfg.svh"
module sre_exec import sre_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // command
  input wire logic start_i,
  input wire sre_cmd_s cmd_i,
  input wire logic page_zero_mode_i,
  output logic busy_o,
  output logic done_o,
  output logic trap_o,
  // stack memory, read data valid while a read is shown
  output sre_mem_s mem_o,
  input wire logic [15:0] mem_rdata_i,
  // register file
  output logic reg_we_o,
  output logic reg_byte_o,
  output logic [3:0] reg_idx_o,
  output logic [15:0] reg_wdata_o,
  output logic [3:0] reg_ridx_o,
  input wire logic [15:0] reg_rdata_i,
  // core state
  output logic [23:0] pc_o,
  output logic [15:0] program_status_word_o,
  output logic [15:0] user_stack_ptr_o,
  output logic [15:0] system_stack_ptr_o,
  output logic special_function_regs_rst_o,
  // configuration straps
  input wire logic external_access_strap_i,
  input wire logic bus_width_strap_i,
  output logic [1:0] cfg_o
);
  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [2:0] lsb_idx(input logic [7:0] m);
    lsb_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) lsb_idx = 3'(i);
    end
  endfunction : lsb_idx

  function automatic logic [2:0] msb_idx(input logic [7:0] m);
    msb_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) msb_idx = 3'(i);
    end
  endfunction : msb_idx

  function automatic logic [7:0] total_of(input sre_cmd_s c, input logic pz);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 8; i++) n = n + {7'h00, c.mask[i]};
    n = (n == 8'h00) ? 8'h00 : n - 8'h01;
    case (c.op)
      SRE_OP_POP_DIR: total_of = `SRE_CYC_POP_DIR;
      SRE_OP_PUSH_DIR: total_of = `SRE_CYC_PUSH_DIR;
      SRE_OP_POP_LIST: total_of = `SRE_CYC_POPL_BASE + 8'(n * `SRE_CYC_POPL_EACH);
      SRE_OP_PUSH_LIST: total_of = `SRE_CYC_PUSHL_BASE + 8'(n * `SRE_CYC_PUSHL_EACH);
      SRE_OP_SWRESET: total_of = `SRE_CYC_SWRESET;
      SRE_OP_RET: total_of = pz ? `SRE_CYC_RET_PZ : `SRE_CYC_RET;
      SRE_OP_INTERRUPT_RETURN: total_of = pz ? `SRE_CYC_INTERRUPT_RETURN_PZ : `SRE_CYC_INTERRUPT_RETURN;
      default: total_of = 8'h01;
    endcase
  endfunction : total_of

  // ************************************************
  // strap capture, once after hardware reset
  // ************************************************
  logic [1:0] strap_raw;
  logic [1:0] sync0_ff;
  logic [1:0] sync1_ff;
  logic [1:0] cfg_ff;
  logic [1:0] nxt_cfg;
  logic [1:0] cap_cnt_ff;
  logic [1:0] nxt_cap_cnt;
  assign strap_raw = {bus_width_strap_i, external_access_strap_i};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sync0_ff[g] <= 1'b0;
        sync1_ff[g] <= 1'b0;
      end else begin
        sync0_ff[g] <= strap_raw[g];
        sync1_ff[g] <= sync0_ff[g];
      end
    end
  end

  // software reset never touches this capture
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_cap_cnt = cap_cnt_ff;
    if (cap_cnt_ff != 2'h3) begin
      nxt_cap_cnt = cap_cnt_ff + 2'h1;
      if (cap_cnt_ff == 2'h2) nxt_cfg = sync1_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ff <= 2'h0;
      cap_cnt_ff <= 2'h0;
    end else begin
      cfg_ff <= nxt_cfg;
      cap_cnt_ff <= nxt_cap_cnt;
    end
  end
  assign cfg_o = cfg_ff;

  // ************************************************
  // executor
  // ************************************************
  sre_state_e state_ff, nxt_state;
  sre_cmd_s cmd_ff, nxt_cmd;
  sre_mem_s mem_ff, nxt_mem;
  logic [7:0] cyc_ff, nxt_cyc, total_ff, nxt_total, mask_ff, nxt_mask;
  logic [1:0] ph_ff, nxt_ph;
  logic [15:0] usp_ff, nxt_usp, ssp_ff, nxt_ssp, psw_ff, nxt_psw, reg_wdata_ff, nxt_reg_wdata;
  logic [23:0] pc_ff, nxt_pc;
  logic done_ff, nxt_done, trap_ff, nxt_trap, sfr_ff, nxt_sfr, reg_we_ff, nxt_reg_we;
  logic [3:0] reg_idx_ff, nxt_reg_idx, reg_ridx_ff, nxt_reg_ridx;
  logic use_usr;
  logic [15:0] cur_sp, nsp;

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_cyc = cyc_ff;
    nxt_total = total_ff;
    nxt_mask = mask_ff;
    nxt_ph = ph_ff;
    nxt_psw = psw_ff;
    nxt_pc = pc_ff;
    nxt_mem = mem_ff;
    nxt_mem.req = 1'b0;
    nxt_mem.we = 1'b0;
    nxt_reg_we = 1'b0;
    nxt_reg_idx = reg_idx_ff;
    nxt_reg_wdata = reg_wdata_ff;
    nxt_reg_ridx = reg_ridx_ff;
    nxt_done = 1'b0;
    nxt_trap = 1'b0;
    nxt_sfr = 1'b0;
    // returns have no user variant: only push and pop honour the user flag
    use_usr = (cmd_ff.op != SRE_OP_INTERRUPT_RETURN) &&
      ((cmd_ff.user_stack && cmd_ff.op != SRE_OP_RET) || !psw_ff[`SRE_PSW_SM_BIT]);
    cur_sp = use_usr ? usp_ff : ssp_ff;
    nsp = cur_sp;
    nxt_usp = usp_ff;
    nxt_ssp = ssp_ff;
    case (state_ff)
      SRE_ST_IDLE: begin
        if (start_i) begin
          nxt_cmd = cmd_i;
          nxt_mask = cmd_i.mask;
          nxt_total = total_of(cmd_i, page_zero_mode_i);
          nxt_cyc = 8'h01;
          nxt_ph = 2'h0;
          nxt_state = SRE_ST_EXEC;
        end
      end
      SRE_ST_EXEC: begin
        nxt_cyc = cyc_ff + 8'h01;
        nxt_ph = ph_ff + 2'h1;
        nxt_mem.byte_mode = 1'b0;
        case (cmd_ff.op)
          SRE_OP_POP_DIR: begin
            nxt_mem.byte_mode = cmd_ff.byte_mode;
            if (ph_ff == 2'h0) begin
              nxt_mem.req = 1'b1;
              nxt_mem.addr = cur_sp;
            end else if (ph_ff == 2'h1) begin
              nxt_mem.req = 1'b1;
              nxt_mem.we = 1'b1;
              nxt_mem.addr = cmd_ff.direct;
              nxt_mem.wdata = mem_rdata_i;
              nsp = cur_sp + `SRE_SP_STEP;
            end else begin
              nxt_ph = 2'h3;
            end
          end
          SRE_OP_PUSH_DIR: begin
            nxt_mem.byte_mode = cmd_ff.byte_mode;
            if (ph_ff == 2'h0) begin
              nsp = cur_sp - `SRE_SP_STEP;
              nxt_mem.req = 1'b1;
              nxt_mem.addr = cmd_ff.direct;
            end else if (ph_ff == 2'h1) begin
              nxt_mem.req = 1'b1;
              nxt_mem.we = 1'b1;
              nxt_mem.addr = cur_sp;
              nxt_mem.wdata = mem_rdata_i;
            end else begin
              // hold phase so the pointer step is not repeated
              nxt_ph = 2'h3;
            end
          end
          SRE_OP_POP_LIST: begin
            nxt_mem.byte_mode = cmd_ff.byte_mode;
            if (mask_ff == 8'h00) begin
              nxt_ph = 2'h0;
            end else if (ph_ff == 2'h0) begin
              nxt_mem.req = 1'b1;
              nxt_mem.addr = cur_sp;
            end else begin
              nxt_reg_we = 1'b1;
              nxt_reg_idx = cmd_ff.byte_mode ? {cmd_ff.upper_group, lsb_idx(mask_ff)} : {1'b0, lsb_idx(mask_ff)};
              nxt_reg_wdata = mem_rdata_i;
              nxt_mask = mask_ff & ~(8'h01 << lsb_idx(mask_ff));
              nsp = cur_sp + `SRE_SP_STEP;
              nxt_ph = 2'h0;
            end
          end
          SRE_OP_PUSH_LIST: begin
            nxt_mem.byte_mode = cmd_ff.byte_mode;
            if (mask_ff == 8'h00) begin
              nxt_ph = 2'h0;
            end else if (ph_ff == 2'h0) begin
              nsp = cur_sp - `SRE_SP_STEP;
              nxt_reg_ridx = cmd_ff.byte_mode ? {cmd_ff.upper_group, msb_idx(mask_ff)} : {1'b0, msb_idx(mask_ff)};
            end else if (ph_ff == 2'h1) begin
              nxt_mem.req = 1'b1;
              nxt_mem.we = 1'b1;
              nxt_mem.addr = cur_sp;
              nxt_mem.wdata = reg_rdata_i;
            end else begin
              nxt_mask = mask_ff & ~(8'h01 << msb_idx(mask_ff));
              nxt_ph = 2'h0;
            end
          end
          SRE_OP_SWRESET: begin
            if (ph_ff == 2'h0) begin
              nxt_mem.req = 1'b1;
              nxt_mem.addr = `SRE_VEC_PSW_ADDR;
            end else if (ph_ff == 2'h1) begin
              nxt_psw = mem_rdata_i;
              nxt_mem.req = 1'b1;
              nxt_mem.addr = `SRE_VEC_PC_ADDR;
            end else if (ph_ff == 2'h2) begin
              nxt_pc = {8'h00, mem_rdata_i};
              nxt_sfr = 1'b1;
              nxt_usp = `SRE_SP_RST;
              nxt_ssp = `SRE_SP_RST;
            end else begin
              nxt_ph = 2'h3;
            end
          end
          SRE_OP_RET: begin
            if (ph_ff == 2'h0) begin
              nxt_mem.req = 1'b1;
              nxt_mem.addr = cur_sp;
            end else if (ph_ff == 2'h1) begin
              nxt_pc = {8'h00, mem_rdata_i};
              nxt_mem.req = !page_zero_mode_i;
              nxt_mem.addr = cur_sp + `SRE_SP_STEP;
              if (page_zero_mode_i) nsp = cur_sp + `SRE_SP_STEP;
            end else if (ph_ff == 2'h2 && !page_zero_mode_i) begin
              nxt_pc = {mem_rdata_i[7:0], pc_ff[15:0]};
              nsp = cur_sp + `SRE_RET_STEP;
            end else begin
              nxt_ph = 2'h3;
            end
          end
          SRE_OP_INTERRUPT_RETURN: begin
            if (ph_ff == 2'h0 && !psw_ff[`SRE_PSW_SM_BIT]) begin
              nxt_trap = 1'b1;
            end else if (ph_ff == 2'h0) begin
              nxt_mem.req = 1'b1;
              nxt_mem.addr = ssp_ff;
            end else if (ph_ff == 2'h1) begin
              nxt_psw = mem_rdata_i;
              nxt_mem.req = 1'b1;
              nxt_mem.addr = ssp_ff + `SRE_SP_STEP;
            end else if (ph_ff == 2'h2) begin
              nxt_pc = {8'h00, mem_rdata_i};
              nxt_mem.req = !page_zero_mode_i;
              nxt_mem.addr = ssp_ff + `SRE_RET_STEP;
              if (page_zero_mode_i) nsp = ssp_ff + `SRE_RET_STEP;
            end else if (mem_ff.req) begin
              nxt_pc = {mem_rdata_i[7:0], pc_ff[15:0]};
              nsp = ssp_ff + `SRE_INTERRUPT_RETURN_STEP;
              nxt_ph = 2'h3;
            end else begin
              nxt_ph = 2'h3;
            end
          end
          default: nxt_ph = 2'h0;
        endcase
        if (cmd_ff.op != SRE_OP_SWRESET) begin
          if (use_usr) nxt_usp = nsp;
          else nxt_ssp = nsp;
        end
        if (cyc_ff == total_ff || nxt_trap) begin
          nxt_done = 1'b1;
          nxt_state = SRE_ST_IDLE;
        end
      end
      default: nxt_state = SRE_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= SRE_ST_IDLE;
      cmd_ff <= '0;
      cyc_ff <= 8'h00;
      total_ff <= 8'h00;
      mask_ff <= 8'h00;
      ph_ff <= 2'h0;
      psw_ff <= `SRE_PSW_RST;
      pc_ff <= `SRE_PC_RST;
      usp_ff <= `SRE_SP_RST;
      ssp_ff <= `SRE_SP_RST;
      mem_ff <= '0;
      reg_we_ff <= 1'b0;
      reg_idx_ff <= 4'h0;
      reg_wdata_ff <= 16'h0000;
      reg_ridx_ff <= 4'h0;
      done_ff <= 1'b0;
      trap_ff <= 1'b0;
      sfr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      cyc_ff <= nxt_cyc;
      total_ff <= nxt_total;
      mask_ff <= nxt_mask;
      ph_ff <= nxt_ph;
      psw_ff <= nxt_psw;
      pc_ff <= nxt_pc;
      usp_ff <= nxt_usp;
      ssp_ff <= nxt_ssp;
      mem_ff <= nxt_mem;
      reg_we_ff <= nxt_reg_we;
      reg_idx_ff <= nxt_reg_idx;
      reg_wdata_ff <= nxt_reg_wdata;
      reg_ridx_ff <= nxt_reg_ridx;
      done_ff <= nxt_done;
      trap_ff <= nxt_trap;
      sfr_ff <= nxt_sfr;
    end
  end

  assign busy_o = state_ff == SRE_ST_EXEC;
  assign done_o = done_ff;
  assign trap_o = trap_ff;
  assign mem_o = mem_ff;
  assign reg_we_o = reg_we_ff;
  assign reg_byte_o = cmd_ff.byte_mode;
  assign reg_idx_o = reg_idx_ff;
  assign reg_wdata_o = reg_wdata_ff;
  assign reg_ridx_o = reg_ridx_ff;
  assign pc_o = pc_ff;
  assign program_status_word_o = psw_ff;
  assign user_stack_ptr_o = usp_ff;
  assign system_stack_ptr_o = ssp_ff;
  assign special_function_regs_rst_o = sfr_ff;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  assign acc = start_i && state_ff == SRE_ST_IDLE;

  property p_pop_dir_len;
    acc && cmd_i.op == SRE_OP_POP_DIR |-> ##6 done_o;
  endproperty
  a_pop_dir_len: assert property (p_pop_dir_len) else $error("direct pop length wrong");
  property p_push_dir_wr;
    acc && cmd_i.op == SRE_OP_PUSH_DIR && (cmd_i.user_stack || !psw_ff[`SRE_PSW_SM_BIT])
      |-> ##3 mem_o.we && mem_o.addr == usp_ff;
  endproperty
  a_push_dir_wr: assert property (p_push_dir_wr) else $error("direct push address wrong");
  property p_user_sel;
    acc && cmd_i.op == SRE_OP_POP_DIR && (cmd_i.user_stack || !psw_ff[`SRE_PSW_SM_BIT])
      |-> ##2 mem_o.req && mem_o.addr == $past(usp_ff, 2);
  endproperty
  a_user_sel: assert property (p_user_sel) else $error("user stack not used");
  property p_pop_order;
    reg_we_o && cmd_ff.op == SRE_OP_POP_LIST |-> reg_idx_o[2:0] == lsb_idx($past(mask_ff));
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("pop list order wrong");
  property p_pop_step;
    reg_we_o && cmd_ff.op == SRE_OP_POP_LIST |-> cur_sp == 16'($past(cur_sp) + `SRE_SP_STEP);
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop list pointer step wrong");
  property p_push_order;
    busy_o && cmd_ff.op == SRE_OP_PUSH_LIST && ph_ff == 2'h1 && mask_ff != 8'h00
      |-> reg_ridx_o[2:0] == msb_idx(mask_ff);
  endproperty
  a_push_order: assert property (p_push_order) else $error("push list order wrong");
  property p_swreset_len;
    acc && cmd_i.op == SRE_OP_SWRESET |-> ##19 done_o;
  endproperty
  a_swreset_len: assert property (p_swreset_len) else $error("reset instruction length wrong");
  property p_cfg_keep;
    special_function_regs_rst_o |-> ##1 $stable(cfg_o);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("straps changed by reset instruction");
  property p_ret_len;
    acc && cmd_i.op == SRE_OP_RET && !page_zero_mode_i |-> ##9 done_o;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return length wrong");
  property p_interrupt_return_trap;
    acc && cmd_i.op == SRE_OP_INTERRUPT_RETURN && !psw_ff[`SRE_PSW_SM_BIT] |-> ##2 trap_o && done_o;
  endproperty
  a_interrupt_return_trap: assert property (p_interrupt_return_trap) else $error("user mode interrupt return not trapped");
  property p_empty;
    acc && cmd_i.op == SRE_OP_POP_LIST && cmd_i.mask == 8'h00 |-> ##5 done_o && $stable(usp_ff);
  endproperty
  a_empty: assert property (p_empty) else $error("empty list changed state");
  c_pop_list: cover property (acc && cmd_i.op == SRE_OP_POP_LIST && cmd_i.mask == 8'hff);
  c_interrupt_return: cover property (done_o && cmd_ff.op == SRE_OP_INTERRUPT_RETURN && !trap_o);
  c_swreset: cover property (special_function_regs_rst_o);
endmodule : sre_exec

// File: sre_cfg.svh
// constants for the stack and return instruction executor
//
// Function
// - A direct pop reads the stack word at the pointer, writes it to the direct location, then adds 2; 3 bytes, 5 clocks.
// - A direct push first subtracts 2 from the pointer, then writes the direct operand there; 3 bytes, 5 clocks.
// - Plain variants use the currently active pointer and user variants always use the user stack pointer.
// - A list pop does one stack read per selected register, from eight words or one group of eight bytes.
// - The mask maps bit 7 down to bit 0 onto R7..R0, R3H..R0L or R7H..R4L.
// - A list pop restores the lowest selected register first.
// - A list push stores the highest selected register first, so push then pop with one mask restores all.
// - Each list pop step loads the register from the pointer then adds 2; 4 clocks plus 2 per extra register.
// - Each list push step subtracts 2 then stores the register; 3 clocks plus 3 per extra register.
// - The reset instruction loads program counter and status word from vector 0, clears both stack pointers, resets special function registers; 18 clocks.
// - A software reset keeps the latched straps and drives no reset pulse off chip.
// - Subroutine return pops a 24-bit address into the program counter and adds 4; 8 clocks, 6 in page zero.
// - In page-zero mode both returns pop only a 16-bit address.
// - Interrupt return pops status word then 24-bit address from the system stack, adds 6; 10 clocks, 8 in page zero.
// - Interrupt return in user mode raises a trap instead of returning.
`ifndef SRE_CFG_SVH
`define SRE_CFG_SVH
`define SRE_CYC_POP_DIR 8'h05
`define SRE_CYC_PUSH_DIR 8'h05
`define SRE_CYC_POPL_BASE 8'h04
`define SRE_CYC_POPL_EACH 8'h02
`define SRE_CYC_PUSHL_BASE 8'h03
`define SRE_CYC_PUSHL_EACH 8'h03
`define SRE_CYC_SWRESET 8'h12
`define SRE_CYC_RET 8'h08
`define SRE_CYC_RET_PZ 8'h06
`define SRE_CYC_INTERRUPT_RETURN 8'h0a
`define SRE_CYC_INTERRUPT_RETURN_PZ 8'h08
`define SRE_SP_STEP 16'h0002
`define SRE_RET_STEP 16'h0004
`define SRE_INTERRUPT_RETURN_STEP 16'h0006
`define SRE_PSW_SM_BIT 15
`define SRE_SP_RST 16'h0000
`define SRE_PSW_RST 16'h8000
`define SRE_PC_RST 24'h000000
`define SRE_VEC_PSW_ADDR 16'h0000
`define SRE_VEC_PC_ADDR 16'h0002
`endif

// File: sre_pkg.sv
// types for the stack and return instruction executor
package sre_pkg;
  typedef enum logic [2:0] {
    SRE_OP_POP_DIR, SRE_OP_PUSH_DIR, SRE_OP_POP_LIST, SRE_OP_PUSH_LIST,
    SRE_OP_SWRESET, SRE_OP_RET, SRE_OP_INTERRUPT_RETURN
  } sre_op_e;
  typedef enum logic [0:0] {SRE_ST_IDLE, SRE_ST_EXEC} sre_state_e;
  typedef struct packed {
    sre_op_e op;
    logic byte_mode;
    logic user_stack;
    logic upper_group;
    logic [7:0] mask;
    logic [15:0] direct;
  } sre_cmd_s;
  typedef struct packed {
    logic req;
    logic we;
    logic byte_mode;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sre_mem_s;
endpackage : sre_pkg

// File: sre_mem_model.sv
// stack data memory model facing the executor
`timescale 1ns/1ps
module sre_mem_model import sre_pkg::*; (
  // clock
  input wire logic core_clk_i,
  // memory port
  input wire sre_mem_s mem_i,
  output logic [15:0] rdata_o
);
  // ****************
  // storage
  // ****************
  logic [15:0] mem [0:32767];
  logic [15:0] last_ff = 16'h0000;
  // idle data bus shows the inverse of the last value
  always_comb begin
    rdata_o = (mem_i.req && !mem_i.we) ? mem[mem_i.addr[15:1]] : ~last_ff;
  end
  always @(posedge core_clk_i) begin
    last_ff <= rdata_o;
    if (mem_i.req && mem_i.we) begin
      if (!mem_i.byte_mode) mem[mem_i.addr[15:1]] <= mem_i.wdata;
      else if (mem_i.addr[0]) mem[mem_i.addr[15:1]][15:8] <= mem_i.wdata[7:0];
      else mem[mem_i.addr[15:1]][7:0] <= mem_i.wdata[7:0];
    end
  end
endmodule : sre_mem_model

// File: tb.sv
// self-checking bench for the stack and return executor
`timescale 1ns/1ps
module tb import sre_pkg::*; ;
  // ****************
  // signals
  // ****************
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start = 1'b0;
  sre_cmd_s cmd = '0;
  sre_cmd_s c = '0;
  logic pz = 1'b0;
  logic ea = 1'b0;
  logic bw = 1'b0;
  logic busy, done, trap, reg_we, reg_byte, sfr_rst, bm, up, us, z, isr;
  sre_mem_s mem;
  logic [15:0] mem_rdata, reg_wdata, reg_rdata, program_status_word, user_stack_ptr, system_stack_ptr, sp0, sp1, p, a, b, r, src, val;
  logic [3:0] reg_idx, reg_ridx;
  logic [23:0] pc, pc0;
  logic [1:0] cfg, cfg0;
  logic [7:0] m;
  logic [15:0] rf [0:7];
  logic [15:0] snap [0:7];
  logic [15:0] ex [0:7];
  logic [31:0] seed = 32'd86164;
  int fails = 0;
  int checks_done = 0;
  int sfr_cnt = 0;
  int n, lo, j, cyc, cnt0;

  always #2.5 core_clk_i = ~core_clk_i;

  sre_exec dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(start), .cmd_i(cmd),
    .page_zero_mode_i(pz), .busy_o(busy), .done_o(done), .trap_o(trap), .mem_o(mem),
    .mem_rdata_i(mem_rdata), .reg_we_o(reg_we), .reg_byte_o(reg_byte), .reg_idx_o(reg_idx),
    .reg_wdata_o(reg_wdata), .reg_ridx_o(reg_ridx), .reg_rdata_i(reg_rdata), .pc_o(pc),
    .program_status_word_o(program_status_word), .user_stack_ptr_o(user_stack_ptr), .system_stack_ptr_o(system_stack_ptr),
    .special_function_regs_rst_o(sfr_rst), .external_access_strap_i(ea),
    .bus_width_strap_i(bw), .cfg_o(cfg));
  sre_mem_model pm (.core_clk_i(core_clk_i), .mem_i(mem), .rdata_o(mem_rdata));

  // register file behind the executor
  always_comb begin
    reg_rdata = reg_byte ? {8'h00, reg_ridx[0] ? rf[reg_ridx[3:1]][15:8] : rf[reg_ridx[3:1]][7:0]} : rf[reg_ridx[2:0]];
  end
  always @(posedge core_clk_i) begin
    if (sfr_rst === 1'b1) sfr_cnt <= sfr_cnt + 1;
    if (reg_we === 1'b1) begin
      if (!reg_byte) rf[reg_idx[2:0]] <= reg_wdata;
      else if (reg_idx[0]) rf[reg_idx[3:1]][15:8] <= reg_wdata[7:0];
      else rf[reg_idx[3:1]][7:0] <= reg_wdata[7:0];
    end
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  function automatic int cyc_exp(sre_op_e op, int cnt, logic zz);
    case (op)
      SRE_OP_POP_LIST: return cnt == 0 ? 4 : 4 + 2 * (cnt - 1);
      SRE_OP_PUSH_LIST: return cnt == 0 ? 3 : 3 + 3 * (cnt - 1);
      SRE_OP_SWRESET: return 18;
      SRE_OP_RET: return zz ? 6 : 8;
      SRE_OP_INTERRUPT_RETURN: return zz ? 8 : 10;
      default: return 5;
    endcase
  endfunction : cyc_exp
  // stored unit of mask bit bb as it sits on the stack
  function automatic logic [15:0] unit_of(int bb);
    logic [15:0] w;
    w = snap[bm ? (up ? 4 : 0) + bb / 2 : bb];
    return !bm ? w : (bb % 2 == 1) ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction : unit_of
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    pm.mem[ad[15:1]] = d;
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic zz, output int cc);
    @(posedge core_clk_i);
    start <= 1'b1;
    cmd <= c;
    pz <= zz;
    @(posedge core_clk_i);
    start <= 1'b0;
    cc = 0;
    do begin
      @(negedge core_clk_i);
      cc++;
    end while (done !== 1'b1 && cc < 60);
  endtask : go
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6000) @(posedge core_clk_i);
    fails++;
    results();
  end

  initial begin
    for (int i = 0; i < 32768; i++) pm.mem[i] = rnd();
    for (int i = 0; i < 8; i++) rf[i] = rnd();
    r = rnd();
    ea = r[0];
    bw = r[1];
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk(cfg, {bw, ea});
    chk(program_status_word, 16'h8000);
    // direct push then pop on the system stack
    r = rnd();
    src = {4'h1, r[11:1], 1'b0};
    val = pm.mem[src[15:1]];
    c = '{SRE_OP_PUSH_DIR, 1'b0, 1'b0, 1'b0, 8'h00, src};
    go(1'b0, cyc);
    chk(cyc, 6);
    chk(busy, 1'b0);
    chk(system_stack_ptr, 16'hfffe);
    chk(pm.mem[15'h7fff], val);
    c.op = SRE_OP_POP_DIR;
    c.direct = {4'h2, r[11:1], 1'b0};
    go(1'b0, cyc);
    chk(cyc, 6);
    chk(pm.mem[c.direct[15:1]], val);
    chk(system_stack_ptr, 16'h0000);
    $display("test direct done");
    // list push then pop, every mode, empty and full masks
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      m = (k % 4 == 0) ? 8'h00 : (k % 4 == 1) ? 8'hff : r[7:0];
      bm = (k / 4) != 0;
      up = (k / 4) == 2;
      us = k[0];
      n = $countones(m);
      sp0 = us ? user_stack_ptr : system_stack_ptr;
      for (int i = 0; i < 8; i++) snap[i] = rf[i];
      c = '{SRE_OP_PUSH_LIST, bm, us, up, m, 16'h0000};
      go(1'b0, cyc);
      chk(cyc, cyc_exp(SRE_OP_PUSH_LIST, n, 1'b0) + 1);
      sp1 = us ? user_stack_ptr : system_stack_ptr;
      chk(sp1, 16'(sp0 - 2 * n));
      lo = 0;
      while (n > 0 && !m[lo]) lo++;
      if (n > 0) chk(pm.mem[sp1[15:1]] & (bm ? 16'h00ff : 16'hffff), unit_of(lo));
      for (int i = 0; i < 8; i++) begin
        rf[i] = rnd();
        ex[i] = rf[i];
      end
      for (int i = 0; i < 8; i++) begin
        j = (up ? 4 : 0) + i / 2;
        if (m[i] && !bm) ex[i] = snap[i];
        if (m[i] && bm) ex[j] = i[0] ? {snap[j][15:8], ex[j][7:0]} : {ex[j][15:8], snap[j][7:0]};
      end
      c.op = SRE_OP_POP_LIST;
      go(1'b0, cyc);
      chk(cyc, cyc_exp(SRE_OP_POP_LIST, n, 1'b0) + 1);
      chk(us ? user_stack_ptr : system_stack_ptr, sp0);
      for (int i = 0; i < 8; i++) chk(rf[i], ex[i]);
    end
    $display("test list done");
    // both returns, with and without page zero
    for (int k = 0; k < 4; k++) begin
      z = (k == 1 || k == 2);
      isr = k > 1;
      sp0 = system_stack_ptr;
      p = rnd();
      a = rnd();
      b = rnd();
      p[15] = z;
      wr(sp0, isr ? p : a);
      wr(sp0 + 16'd2, isr ? a : b);
      wr(sp0 + 16'd4, b);
      c.op = isr ? SRE_OP_INTERRUPT_RETURN : SRE_OP_RET;
      go(z, cyc);
      chk(cyc, cyc_exp(c.op, 0, z) + 1);
      chk(pc, z ? {8'h00, a} : {b[7:0], a});
      chk(system_stack_ptr, 16'(sp0 + (z ? 2 : 4) + (isr ? 2 : 0)));
      if (isr) chk(program_status_word, p);
    end
    $display("test return done");
    // user mode now: return refused, plain push goes to the user stack
    sp0 = system_stack_ptr;
    pc0 = pc;
    sp1 = user_stack_ptr;
    c.op = SRE_OP_INTERRUPT_RETURN;
    go(1'b0, cyc);
    chk(cyc, 2);
    chk(trap, 1'b1);
    chk(system_stack_ptr, sp0);
    chk(pc, pc0);
    c = '{SRE_OP_PUSH_DIR, 1'b0, 1'b0, 1'b0, 8'h00, src};
    go(1'b0, cyc);
    chk(user_stack_ptr, 16'(sp1 - 2));
    chk(system_stack_ptr, sp0);
    c.op = SRE_OP_POP_DIR;
    go(1'b0, cyc);
    chk(cyc, cyc_exp(SRE_OP_POP_DIR, 0, 1'b0) + 1);
    chk(user_stack_ptr, sp1);
    chk(system_stack_ptr, sp0);
    $display("test user done");
    // software reset keeps the latched straps
    @(posedge core_clk_i);
    ea <= ~ea;
    bw <= ~bw;
    cfg0 = cfg;
    p = rnd();
    a = rnd();
    wr(16'h0000, p);
    wr(16'h0002, a);
    cnt0 = sfr_cnt;
    c.op = SRE_OP_SWRESET;
    go(1'b0, cyc);
    chk(cyc, 19);
    chk(program_status_word, p);
    chk(pc, {8'h00, a});
    chk({user_stack_ptr, system_stack_ptr}, 32'h0);
    chk(sfr_cnt - cnt0, 1);
    chk(cfg, cfg0);
    $display("test reset done");
    results();
  end
endmodule : tb
